// File: hw/nbl_host.sv
`timescale 1ns/1ps

// Word FIFO with registered flags
module nbl_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // Fill side
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  // Drain side
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]   count, next_count;
  logic          push, pop;
  logic [W-1:0]  next_data;

  // Pointer and flag update
  always_comb begin
    push        = in_valid_in && in_ready_out;
    pop         = out_valid_out && out_ready_in;
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count  = (AW+1)'(count + {{AW{1'b0}}, push}
                  - {{AW{1'b0}}, pop});
    // Head word after this edge; a word landing on it bypasses memory
    next_data   = (push && wr_ptr == next_rd_ptr) ? in_data_in
                                                  : mem[next_rd_ptr];
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr        <= '0;
      rd_ptr        <= '0;
      count         <= '0;
      in_ready_out  <= 1'b1;
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end else begin
      wr_ptr        <= next_wr_ptr;
      rd_ptr        <= next_rd_ptr;
      count         <= next_count;
      in_ready_out  <= next_count != (AW+1)'(DEPTH);
      out_valid_out <= next_count != '0;
      out_data_out  <= next_data;
    end
  end

  // Storage
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

endmodule : nbl_fifo

// Host controller driving the NAND pins
module nbl_host
  import nbl_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Request port
  input  wire logic             req_valid_in,
  output logic                  req_ready_out,
  input  wire nbl_req_t         req_in,
  input  wire logic             bus16_in,
  input  wire logic             write_enable_in,
  // Write data stream
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [BUS_W-1:0] wr_data_in,
  // Read data stream
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic [BUS_W-1:0]      rd_data_out,
  // Device pins
  output nbl_pins_t             ctrl_out,
  output logic [BUS_W-1:0]      io_out,
  output logic                  io_oe_n_out,
  input  wire logic [BUS_W-1:0] io_in,
  input  wire logic             ready_busy_n_in
);
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_SETUP = 7'h02,
    ST_WLOW  = 7'h04,
    ST_WHIGH = 7'h08,
    ST_RLOW  = 7'h10,
    ST_RHIGH = 7'h20,
    ST_WAIT  = 7'h40
  } nbl_state_t;

  nbl_state_t       state, next_state;
  nbl_req_t         req, next_req;
  nbl_pins_t        pins, next_pins;
  logic [7:0]       cnt, next_cnt;
  logic [CNT_W-1:0] beat, next_beat;
  logic [BUS_W-1:0] io, next_io;
  logic             oe_n, next_oe_n, req_rdy, next_req_rdy;
  logic             wf_valid, wf_pop, rf_ready, rf_push;
  logic [BUS_W-1:0] wf_data, rf_data;
  logic             last_beat;

  // Address byte for a given cycle; lines 15..8 stay low
  function automatic logic [7:0] addr_byte(
    input logic [2:0] idx,
    input nbl_req_t   r,
    input logic       wide
  );
    logic [7:0] b;
    b = 8'h00;
    if (idx == 3'h0) begin
      b = r.col[7:0];
    end else if (idx == 3'h1) begin
      b = wide ? {5'h00, r.col[10:8]} : {4'h0, r.col[11:8]};
    end else if (idx == 3'h2) begin
      b = r.row[7:0];
    end else if (idx == 3'h3) begin
      b = r.row[15:8];
    end else if (idx == 3'h4) begin
      b = {7'h00, r.row[16]};
    end
    return b;
  endfunction : addr_byte

  // Narrow data to the active bus width
  function automatic logic [BUS_W-1:0] bus_mask(
    input logic [BUS_W-1:0] d,
    input logic             wide
  );
    return wide ? d : {8'h00, d[7:0]};
  endfunction : bus_mask

  // Buffers in both data paths
  nbl_fifo #(.W(BUS_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (wr_valid_in),
    .in_ready_out  (wr_ready_out),
    .in_data_in    (wr_data_in),
    .out_valid_out (wf_valid),
    .out_ready_in  (wf_pop),
    .out_data_out  (wf_data)
  );

  nbl_fifo #(.W(BUS_W), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (rf_push),
    .in_ready_out  (rf_ready),
    .in_data_in    (rf_data),
    .out_valid_out (rd_valid_out),
    .out_ready_in  (rd_ready_in),
    .out_data_out  (rd_data_out)
  );

  // Sequencer next state
  always_comb begin
    next_state = state;
    next_req   = req;
    next_pins  = pins;
    next_cnt   = cnt;
    next_beat  = beat;
    next_io    = io;
    next_oe_n  = oe_n;
    wf_pop     = 1'b0;
    rf_push    = 1'b0;
    rf_data    = bus_mask(io_in, bus16_in);
    last_beat  = 1'b1;
    if (req.op == NBL_OP_ADDR) begin
      last_beat = beat == CNT_W'(ADDR_CYCLES - 1);
    end else if (req.op == NBL_OP_WRITE || req.op == NBL_OP_READ) begin
      last_beat = beat == CNT_W'(req.count - 1'b1);
    end
    case (state)
      ST_IDLE: begin
        next_pins.ce_n = 1'b1;
        next_oe_n      = 1'b1;
        if (ready_busy_n_in) begin
          next_pins.wp_n = write_enable_in;
        end
        if (req_valid_in && req_rdy) begin
          next_req  = req_in;
          next_beat = '0;
          if (req_in.op == NBL_OP_WAIT) begin
            next_cnt   = 8'(WB_CYC - 1);
            next_state = ST_WAIT;
          end else begin
            next_pins.ce_n = 1'b0;
            next_state     = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        next_pins.cle = req.op == NBL_OP_CMD;
        next_pins.ale = req.op == NBL_OP_ADDR;
        if (req.op == NBL_OP_READ) begin
          next_oe_n = 1'b1;
          if (rf_ready) begin
            next_pins.read_strobe_n = 1'b0;
            next_cnt   = 8'(REA_CYC - 1);
            next_state = ST_RLOW;
          end
        end else if (req.op != NBL_OP_WRITE || wf_valid) begin
          if (req.op == NBL_OP_CMD) begin
            next_io = {8'h00, req.cmd};
          end else if (req.op == NBL_OP_ADDR) begin
            next_io = {8'h00, addr_byte(beat[2:0], req, bus16_in)};
          end else begin
            next_io = bus_mask(wf_data, bus16_in);
            wf_pop  = 1'b1;
          end
          next_oe_n      = 1'b0;
          next_pins.we_n = 1'b0;
          next_cnt       = 8'(WP_CYC - 1);
          next_state     = ST_WLOW;
        end
      end
      ST_WLOW: begin
        if (cnt == '0) begin
          next_pins.we_n = 1'b1;
          next_cnt       = 8'(WH_CYC - 1);
          next_state     = ST_WHIGH;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      ST_RLOW: begin
        if (cnt == '0) begin
          rf_push = 1'b1;
          next_pins.read_strobe_n = 1'b1;
          next_cnt   = 8'(REH_CYC - 1);
          next_state = ST_RHIGH;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      ST_WHIGH, ST_RHIGH: begin
        if (cnt != '0) begin
          next_cnt = cnt - 8'h01;
        end else begin
          next_beat = beat + 1'b1;
          if (last_beat) begin
            next_pins.ce_n = 1'b1;
            next_pins.cle  = 1'b0;
            next_pins.ale  = 1'b0;
            next_oe_n      = 1'b1;
            next_state     = ST_IDLE;
          end else begin
            next_state = ST_SETUP;
          end
        end
      end
      ST_WAIT: begin
        if (cnt != '0) begin
          next_cnt = cnt - 8'h01;
        end else if (ready_busy_n_in) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_req_rdy = next_state == ST_IDLE;
  end

  // Sequencer registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state   <= ST_IDLE;
      req     <= '0;
      pins    <= PINS_IDLE;
      cnt     <= '0;
      beat    <= '0;
      io      <= '0;
      oe_n    <= 1'b1;
      req_rdy <= 1'b0;
    end else begin
      state   <= next_state;
      req     <= next_req;
      pins    <= next_pins;
      cnt     <= next_cnt;
      beat    <= next_beat;
      io      <= next_io;
      oe_n    <= next_oe_n;
      req_rdy <= next_req_rdy;
    end
  end

  assign ctrl_out      = pins;
  assign io_out        = io;
  assign io_oe_n_out   = oe_n;
  assign req_ready_out = req_rdy;

  // Checks
  sequence s_read_low;
    !pins.read_strobe_n [*3];
  endsequence

  property p_ce_idle;
    @(posedge clk_in) disable iff (rst_in)
    state == ST_IDLE && $past(state) == ST_IDLE |-> pins.ce_n;
  endproperty
  a_ce_idle: assert property (p_ce_idle)
    else $error("chip select low while idle");

  property p_we_rise_sel;
    @(posedge clk_in) disable iff (rst_in)
    $rose(pins.we_n) |-> !pins.ce_n && !oe_n && (pins.cle || pins.ale
      || req.op == NBL_OP_WRITE);
  endproperty
  a_we_rise_sel: assert property (p_we_rise_sel)
    else $error("write strobe rose without select or drive");

  property p_strobe_excl;
    @(posedge clk_in) disable iff (rst_in)
    !(pins.cle && pins.ale);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl)
    else $error("command and address strobes both high");

  property p_addr_upper;
    @(posedge clk_in) disable iff (rst_in)
    pins.ale && !pins.we_n |-> io[15:8] == 8'h00
      && (beat != '0 || io[7:0] == req.col[7:0]);
  endproperty
  a_addr_upper: assert property (p_addr_upper)
    else $error("address cycle upper lines not low");

  property p_addr_col_hi;
    @(posedge clk_in) disable iff (rst_in)
    pins.ale && !pins.we_n && beat == CNT_W'(1) |->
      io[7:0] == (bus16_in ? {5'h00, req.col[10:8]}
                           : {4'h0, req.col[11:8]});
  endproperty
  a_addr_col_hi: assert property (p_addr_col_hi)
    else $error("second address cycle wrong");

  property p_addr_row_top;
    @(posedge clk_in) disable iff (rst_in)
    pins.ale && !pins.we_n && beat == CNT_W'(4) |->
      io[7:0] == {7'h00, req.row[16]};
  endproperty
  a_addr_row_top: assert property (p_addr_row_top)
    else $error("fifth address cycle wrong");

  property p_read_cond;
    @(posedge clk_in) disable iff (rst_in)
    !pins.read_strobe_n |-> !pins.cle && !pins.ale && pins.we_n
      && !pins.ce_n && oe_n;
  endproperty
  a_read_cond: assert property (p_read_cond)
    else $error("read strobe low in wrong bus state");

  property p_read_hold;
    @(posedge clk_in) disable iff (rst_in)
    $fell(pins.read_strobe_n) |-> s_read_low;
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("read strobe low shorter than access delay");

  property p_wp_busy;
    @(posedge clk_in) disable iff (rst_in)
    !$past(ready_busy_n_in) |-> $stable(pins.wp_n) && pins.read_strobe_n
      || state != ST_WAIT;
  endproperty
  a_wp_busy: assert property (p_wp_busy)
    else $error("write protect moved during busy");

  property p_wait_done;
    @(posedge clk_in) disable iff (rst_in)
    state == ST_WAIT && cnt == '0 && ready_busy_n_in |=> state == ST_IDLE;
  endproperty
  a_wait_done: assert property (p_wait_done)
    else $error("wait did not end on ready");
endmodule : nbl_host

// File: hw/nbl_pkg.sv
// Operation
// - Bus activity is accepted only while the host holds chip select low.
// - Address strobe high steers write strobe rising edge into address register.
// - Command strobe high steers write strobe rising edge into command register.
// - 8-bit bus: cycles one and two carry column A0-A11, upper nibble low.
// - 8-bit bus: cycles three to five carry row A12-A28; A18 picks plane.
// - 16-bit bus: column A0-A10 in two cycles; lines 15..8 always low.
// - 16-bit bus: cycles three to five carry row A11-A27; A17 picks plane.
// - Host drives every unused address bit low during address cycles.
// - Serial read: latch strobes low, chip select low, write strobe high.
// - Shared I/O lines carry command, address and data, told by strobes.
package nbl_pkg;

  // Clock and pin timing
  localparam int CLK_MHZ     = 125;
  localparam int T_WP_NS     = 12;   // Write strobe low
  localparam int T_WH_NS     = 10;   // Write strobe high
  localparam int T_REA_NS    = 20;   // read_access_delay
  localparam int T_REH_NS    = 10;   // Read strobe high
  localparam int T_WB_NS     = 100;  // Strobe to busy
  localparam int WP_CYC  = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int WH_CYC  = (T_WH_NS * CLK_MHZ + 999) / 1000;
  localparam int REA_CYC = (T_REA_NS * CLK_MHZ + 999) / 1000;
  localparam int REH_CYC = (T_REH_NS * CLK_MHZ + 999) / 1000;
  localparam int WB_CYC  = (T_WB_NS * CLK_MHZ + 999) / 1000;

  // Geometry and address layout
  localparam int BUS_W       = 16;
  localparam int COL_W       = 12;
  localparam int ROW_W       = 17;
  localparam int CNT_W       = 12;
  localparam int PAGES_PER_BLOCK = 64;
  localparam int PAGE_MAIN_BYTES = 2048;
  localparam int PAGE_SPARE_BYTES = 128;
  localparam int ADDR_CYCLES = 5;
  localparam int PLANE_ROW_BIT = 6;  // A18 on x8, A17 on x16
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;

  // Host operations
  typedef enum logic [2:0] {
    NBL_OP_CMD   = 3'h0,
    NBL_OP_ADDR  = 3'h1,
    NBL_OP_WRITE = 3'h2,
    NBL_OP_READ  = 3'h3,
    NBL_OP_WAIT  = 3'h4
  } nbl_op_t;

  // One request from the user side
  typedef struct packed {
    nbl_op_t          op;
    logic [7:0]       cmd;
    logic [COL_W-1:0] col;
    logic [ROW_W-1:0] row;
    logic [CNT_W-1:0] count;
  } nbl_req_t;

  // Control pins toward the device
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
    logic wp_n;
  } nbl_pins_t;

  localparam nbl_pins_t PINS_IDLE = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

endpackage : nbl_pkg

// File: tb/nbl_dev_model.sv
`timescale 1ns/1ps

// Behavioural flash device facing the host pins
module nbl_dev_model
  import nbl_pkg::*;
(
  // Host pins
  input  wire nbl_pins_t        pins_in,
  input  wire logic [BUS_W-1:0] host_io_in,
  input  wire logic             host_oe_n_in,
  // Resolved lines back to the host
  output logic [BUS_W-1:0]      io_out,
  output logic                  ready_busy_n_out
);
  logic [7:0]       cmd_q = CMD_READ_SETUP;  // Power-up read setup
  logic [BUS_W-1:0] ab [5];
  logic [BUS_W-1:0] wd [8];
  logic [BUS_W-1:0] drv_val = '0;
  logic [BUS_W-1:0] last = '0;
  logic             drv = 1'b0;
  logic             plane;
  logic [COL_W-1:0] col = '0;
  int               na = 0;
  int               wn = 0;
  int               progs = 0;
  int               reads = 0;
  int               over = 0;

  initial ready_busy_n_out = 1'b1;

  // Released lines show the inverse of the last value
  always_comb begin
    io_out = ~last;
    if (!host_oe_n_in)
      io_out = host_io_in;
    else if (drv && !pins_in.ce_n)
      io_out = drv_val;
  end

  // Latch on write strobe rise, steered by latch strobes
  always @(posedge pins_in.we_n) if (!pins_in.ce_n) begin
    last = io_out;
    if (pins_in.cle) begin
      cmd_q = io_out[7:0];
      na = 0;
      if (cmd_q == 8'h30) begin  // Array read busy
        reads++;
        ready_busy_n_out <= 1'b0;
        ready_busy_n_out <= #200 1'b1;
      end
      if ((cmd_q == 8'h10 || cmd_q == 8'hD0) && pins_in.wp_n) begin
        progs++;
        ready_busy_n_out <= 1'b0;
        ready_busy_n_out <= #400 1'b1;
      end
    end else if (pins_in.ale) begin
      if (na < ADDR_CYCLES)
        ab[na] = io_out;  // Extra cycles dropped
      na++;
      col = {ab[1][3:0], ab[0][7:0]};
      plane = ab[2][PLANE_ROW_BIT];
    end else if (wn < 8) begin
      wd[wn] = io_out;
      wn++;
    end
  end

  // Next word after the access delay, column steps
  always @(negedge pins_in.read_strobe_n) if (!pins_in.ce_n) begin
    drv_val <= #(T_REA_NS) {~col[7:0], col[7:0] + 8'h11};
    last <= #(T_REA_NS) {~col[7:0], col[7:0] + 8'h11};
    drv <= #(T_REA_NS) 1'b1;
    // Reads past the page end
    if (col >= COL_W'(PAGE_MAIN_BYTES + PAGE_SPARE_BYTES)) over++;
    col <= col + 1'b1;
  end

  // Short hold after the strobe rises
  always @(posedge pins_in.read_strobe_n) drv <= #2 1'b0;

endmodule : nbl_dev_model

// File: tb/nbl_host_tb_top.sv
`timescale 1ns/1ps

module nbl_host_tb_top;
  import nbl_pkg::*;
  logic             clk_in = 1'b0;
  logic             rst_in = 1'b1;
  logic             req_valid_in = 1'b0;
  logic             bus16_in = 1'b0;
  logic             write_enable_in = 1'b1;
  logic             wr_valid_in = 1'b0;
  logic             rd_ready_in = 1'b0;
  nbl_req_t         req_in = '0;
  logic [BUS_W-1:0] wr_data_in = '0;
  logic [BUS_W-1:0] io_out, io_lv, rd_data_out;
  logic             req_ready_out, wr_ready_out, rd_valid_out;
  logic             io_oe_n_out, rb_n;
  nbl_pins_t        ctrl_out;
  int               err_total = 0;
  int               checks = 0;
  int               cyc = 0;

  // Clock
  always #4 clk_in = ~clk_in;

  nbl_host #(.FIFO_DEPTH(8)) uut (
    .clk_in(clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
    .req_ready_out(req_ready_out), .req_in(req_in), .bus16_in(bus16_in),
    .write_enable_in(write_enable_in), .wr_valid_in(wr_valid_in),
    .wr_ready_out(wr_ready_out), .wr_data_in(wr_data_in),
    .rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in),
    .rd_data_out(rd_data_out), .ctrl_out(ctrl_out), .io_out(io_out),
    .io_oe_n_out(io_oe_n_out), .io_in(io_lv), .ready_busy_n_in(rb_n));

  nbl_dev_model dev (
    .pins_in(ctrl_out), .host_io_in(io_out), .host_oe_n_in(io_oe_n_out),
    .io_out(io_lv), .ready_busy_n_out(rb_n));

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task results();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  // Wait until the host is idle again
  task wait_idle();
    int k;
    k = 0;
    do @(negedge clk_in); while (!req_ready_out && ++k < 3000);
  endtask : wait_idle

  // One request, held until taken
  task send(input nbl_op_t op, input logic [7:0] c,
            input logic [COL_W-1:0] cl, input logic [ROW_W-1:0] rw,
            input logic [CNT_W-1:0] n, input bit fin);
    int k;
    @(negedge clk_in);
    req_in = '{op, c, cl, rw, n};
    req_valid_in = 1'b1;
    k = 0;
    while (!req_ready_out && ++k < 3000) @(negedge clk_in);
    @(negedge clk_in);
    req_valid_in = 1'b0;
    if (fin)
      wait_idle();
  endtask : send

  task t_addr(input logic b16, input logic [COL_W-1:0] c,
              input logic [ROW_W-1:0] r);
    logic [BUS_W-1:0] e [5];
    bus16_in = b16;
    e = '{{8'h00, c[7:0]},
          {12'h000, b16 ? {1'b0, c[10:8]} : c[11:8]},
          {8'h00, r[7:0]}, {8'h00, r[15:8]}, {15'h0000, r[16]}};
    send(NBL_OP_CMD, CMD_READ_SETUP, '0, '0, '0, 1);
    send(NBL_OP_ADDR, 8'h00, c, r, '0, 1);
    for (int i = 0; i < 5; i++) begin
      chk("addr cycle", dev.ab[i], e[i]);
    end
    chk("plane", dev.plane, r[6]);
    chk("addr count", dev.na, 5);
  endtask : t_addr

  task t_write();
    int k;
    bus16_in = 1'b1;
    @(negedge clk_in);
    for (int i = 0; i < 8; i++) begin
      wr_valid_in = 1'b1;
      wr_data_in = 16'h5A00 + i[15:0];
      k = 0;
      while (!wr_ready_out && ++k < 50) @(negedge clk_in);
      @(negedge clk_in);
    end
    wr_valid_in = 1'b0;
    chk("fifo full", wr_ready_out, 1'b0);
    send(NBL_OP_CMD, 8'h80, '0, '0, '0, 1);
    send(NBL_OP_ADDR, 8'h00, 12'h000, 17'h00040, '0, 1);
    send(NBL_OP_WRITE, 8'h00, '0, '0, 12'h008, 1);
    chk("fifo drained", wr_ready_out, 1'b1);
    send(NBL_OP_CMD, 8'h10, '0, '0, '0, 1);
    send(NBL_OP_WAIT, 8'h00, '0, '0, '0, 1);
    chk("wr words", dev.wn, 8);
    chk("wr first", dev.wd[0], 16'h5A00);
    chk("wr last", dev.wd[7], 16'h5A07);
    chk("program", {dev.progs[3:0], rb_n}, 5'h03);
  endtask : t_write

  task t_wp();
    @(negedge clk_in);
    write_enable_in = 1'b0;
    repeat (4) @(negedge clk_in);
    chk("wp pin", ctrl_out.wp_n, 1'b0);
    send(NBL_OP_CMD, 8'h10, '0, '0, '0, 1);
    chk("wp cmd", dev.cmd_q, 8'h10);
    chk("wp refused", {dev.progs[3:0], rb_n}, 5'h03);
    write_enable_in = 1'b1;
  endtask : t_wp

  task t_read(input logic b16, input logic [COL_W-1:0] c0);
    logic [COL_W-1:0] c;
    int n, k;
    bus16_in = b16;
    send(NBL_OP_CMD, 8'h00, '0, '0, '0, 1);
    send(NBL_OP_ADDR, 8'h00, c0, 17'h00123, '0, 1);
    send(NBL_OP_CMD, 8'h30, '0, '0, '0, 1);
    send(NBL_OP_WAIT, 8'h00, '0, '0, '0, 1);
    chk("busy done", rb_n, 1'b1);
    send(NBL_OP_READ, 8'h00, '0, '0, 12'h00A, 0);
    repeat (150) @(negedge clk_in);
    chk("rd stall", {rd_valid_out, req_ready_out}, 2'b10);
    chk("rd strobe", ctrl_out.read_strobe_n, 1'b1);
    rd_ready_in = 1'b1;
    n = 0;
    k = 0;
    while (n < 10 && k < 400) begin
      if (rd_valid_out) begin
        c = c0 + n[COL_W-1:0];
        chk("rd data", rd_data_out,
            {b16 ? ~c[7:0] : 8'h00, c[7:0] + 8'h11});
        n++;
      end
      if (!ctrl_out.read_strobe_n)
        chk("rd pins", ctrl_out[5:2], 4'b0001);
      @(negedge clk_in);
      k++;
    end
    chk("rd count", n, 10);
    chk("rd in page", dev.over, 0);
    wait_idle();
    rd_ready_in = 1'b0;
    chk("rd empty", rd_valid_out, 1'b0);
  endtask : t_read

  // Cut a hang short
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      results();
    end
  end

  // Main sequence
  initial begin
    repeat (2) @(negedge clk_in);
    chk("rst pins", ctrl_out, PINS_IDLE);
    chk("rst oe", {io_oe_n_out, req_ready_out}, 2'b10);
    rst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk("idle", {req_ready_out, ctrl_out.wp_n}, 2'b11);
    chk("preload", dev.cmd_q, CMD_READ_SETUP);
    send(NBL_OP_CMD, 8'hFF, '0, '0, '0, 1);
    chk("cmd", dev.cmd_q, 8'hFF);
    chk("standby", {ctrl_out.ce_n, io_oe_n_out}, 2'b11);
    t_addr(1'b0, 12'hABC, 17'h1A53C);
    t_addr(1'b1, 12'hFBC, 17'h0C3A5);
    t_write();
    t_wp();
    t_read(1'b0, 12'h7FC);
    t_read(1'b1, 12'h010);
    results();
  end

endmodule : nbl_host_tb_top
